/* rtl/hcb_host.sv */
// Host end: APB registers issue control byte commands over the link.
// Assumes an APB master on clk; sck is made here by dividing clk.
`default_nettype none
module hcb_host #(
  parameter int unsigned RESET_WAIT_CYC = hcb_pkg::HOST_RESET_WAIT_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  hcb_if.host link
);
  import hcb_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP, H_WAIT} hcb_host_state_e;

  hcb_host_state_e state_q;
  logic [1:0] hc_q;
  logic sck_q, sel_q, mosi_q, miso_m_q, miso_s_q;
  logic [5:0] pc_q;
  logic [15:0] tx_q, resp_q;
  logic [5:0] ncmd_q, nresp_q;
  logic is_read_q, start_q, done_q, stop_last_q;
  logic [7:0] wr_data_q, stat_byte_q, rdata_q;
  logic [9:0] cmd_q;
  logic [HOST_WAIT_W-1:0] wait_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic tick, rise_t, fall_t, apb_wr, cmd_wr, accept, frame_end;
  logic [7:0] wdat;
  logic [7:0] stat_now;
  logic [5:0] resp_start, frame_len;

  assign tick = hc_q == SCK_HALF;
  assign rise_t = tick && !sck_q;
  assign fall_t = tick && sck_q;
  assign apb_wr = psel && penable && pready_q && pwrite;
  assign cmd_wr = apb_wr && paddr == ADDR_CMD;
  assign accept = cmd_wr && state_q == H_IDLE && !start_q
                  && (pwdata[9:8] == OP_WRITE_CTRL
                      || pwdata[9:8] == OP_READ_CTRL);
  assign resp_start = ncmd_q + PIPE_PERIODS;
  assign frame_len = resp_start + nresp_q;
  assign frame_end = fall_t && state_q == H_RUN && pc_q + 6'h01 == frame_len;
  assign stat_now = (nresp_q == 6'h10) ? resp_q[15:8] : resp_q[7:0];

  // Outgoing data byte fix-ups
  always_comb begin
    wdat = pwdata[7:0] & ~CTRL_RSV_MASK;
    if (stop_last_q && !pwdata[RF_STOP_BIT]) begin
      wdat[RESET_REQ_BIT] = 1'b1;
    end
  end

  // Link clock divider
  always_ff @(posedge clk) begin
    if (rst) begin
      hc_q <= 2'h0;
      sck_q <= 1'b0;
    end else if (ce) begin
      hc_q <= tick ? 2'h0 : hc_q + 2'h1;
      if (tick) begin
        sck_q <= ~sck_q;
      end
    end
  end

  // Return data synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else if (ce) begin
      miso_m_q <= link.miso;
      miso_s_q <= miso_m_q;
    end
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= H_IDLE;
      start_q <= 1'b0;
      sel_q <= 1'b0;
      mosi_q <= 1'b0;
      pc_q <= 6'h00;
      tx_q <= 16'h0000;
      resp_q <= 16'h0000;
      ncmd_q <= 6'h08;
      nresp_q <= 6'h08;
      is_read_q <= 1'b0;
      wr_data_q <= 8'h00;
      wait_q <= '0;
    end else if (ce) begin
      case (state_q)
        H_IDLE: begin
          if (accept) begin
            start_q <= 1'b1;
            is_read_q <= pwdata[9:8] == OP_READ_CTRL;
            wr_data_q <= wdat;
            if (pwdata[9:8] == OP_READ_CTRL) begin
              tx_q <= {CODE_READ_CTRL, 8'h00};
              ncmd_q <= 6'h08;
              nresp_q <= 6'h10;
            end else begin
              tx_q <= {CODE_WRITE_CTRL, wdat};
              ncmd_q <= 6'h10;
              nresp_q <= 6'h08;
            end
          end else if (start_q && fall_t) begin
            start_q <= 1'b0;
            state_q <= H_RUN;
            sel_q <= 1'b1;
            mosi_q <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
            pc_q <= 6'h00;
          end
        end
        H_RUN: begin
          if (rise_t && pc_q >= resp_start && pc_q < frame_len) begin
            resp_q <= {resp_q[14:0], miso_s_q};
            if (is_read_q && pc_q == resp_start + 6'h07
                && resp_q[2:0] != RES_NORMAL[3:1]
                || is_read_q && pc_q == resp_start + 6'h07
                && miso_s_q != RES_NORMAL[0]) begin
              nresp_q <= 6'h08;
            end
          end
          if (frame_end) begin
            state_q <= H_GAP;
            sel_q <= 1'b0;
            mosi_q <= 1'b0;
            pc_q <= 6'h00;
          end else if (fall_t) begin
            pc_q <= pc_q + 6'h01;
            mosi_q <= (pc_q + 6'h01 < ncmd_q) ? tx_q[15] : 1'b0;
            tx_q <= {tx_q[14:0], 1'b0};
          end
        end
        H_GAP: begin
          if (fall_t) begin
            pc_q <= pc_q + 6'h01;
            if (pc_q == GAP_PERIODS - 6'h01) begin
              if (!is_read_q && wr_data_q[RESET_REQ_BIT]
                  && stat_now[3:0] == RES_NORMAL) begin
                state_q <= H_WAIT;
                wait_q <= HOST_WAIT_W'(RESET_WAIT_CYC);
              end else begin
                state_q <= H_IDLE;
              end
            end
          end
        end
        H_WAIT: begin
          wait_q <= wait_q - HOST_WAIT_W'(1);
          if (wait_q == HOST_WAIT_W'(1)) begin
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // Results and completion flag
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      stat_byte_q <= 8'h00;
      rdata_q <= 8'h00;
      stop_last_q <= 1'b0;
    end else if (ce) begin
      if (state_q == H_GAP && fall_t && pc_q == 6'h00) begin
        done_q <= 1'b1;
        stat_byte_q <= stat_now;
        if (is_read_q && nresp_q == 6'h10) begin
          rdata_q <= resp_q[7:0];
        end
        if (!is_read_q && stat_now[3:0] == RES_NORMAL) begin
          stop_last_q <= wr_data_q[RF_STOP_BIT]
                         & ~wr_data_q[RESET_REQ_BIT];
        end
      end else if (apb_wr && paddr == ADDR_STAT
                   && pwdata[STAT_DONE_BIT]) begin
        done_q <= 1'b0;
      end
    end
  end

  // APB slave, one wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      cmd_q <= 10'h000;
    end else if (ce) begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (accept) begin
        cmd_q <= {pwdata[9:8], wdat};
      end
      if (psel && penable && !pready_q) begin
        case (paddr)
          ADDR_CMD: prdata_q <= {22'h000000, cmd_q};
          ADDR_STAT: begin
            prdata_q[STAT_BUSY_BIT] <= state_q != H_IDLE || start_q;
            prdata_q[STAT_DONE_BIT] <= done_q;
            prdata_q[STAT_WAIT_BIT] <= state_q == H_WAIT;
            prdata_q[STAT_STOP_BIT] <= stop_last_q;
            prdata_q[15:8] <= stat_byte_q;
          end
          ADDR_DATA: prdata_q <= {24'h000000, rdata_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign link.sck = sck_q;
  assign link.sel = sel_q;
  assign link.mosi = mosi_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : hcb_host
`default_nettype wire

/* pkg/hcb_pkg.sv */
// Constants shared by both ends of the host control byte link.
// Assumes the device end runs on the link clock and the host on clk.
`default_nettype none
package hcb_pkg;
  // Command codes and result codes
  localparam logic [7:0] CODE_READ_CTRL = 8'h68;
  localparam logic [7:0] CODE_WRITE_CTRL = 8'h78;
  localparam logic [3:0] RES_NORMAL = 4'h5;
  localparam logic [3:0] RES_BUSY = 4'h7;
  localparam logic [3:0] RES_UNIMPL = 4'h8;
  // Control byte fields
  localparam int MASK_RFWR_BIT = 7;
  localparam int MASK_RFRD_BIT = 6;
  localparam int MASK_RFTX_BIT = 5;
  localparam int MASK_FDET_BIT = 4;
  localparam int RF_STOP_BIT = 3;
  localparam int RESET_REQ_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RSV_MASK = 8'h06;
  // Timing
  localparam int SYS_CLK_NS = 20;
  localparam int LINK_CLK_NS = 125;
  localparam int SELF_RESET_NS = 3000000;
  localparam int HOST_RESET_WAIT_CYC =
    (SELF_RESET_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int DEV_RESET_CYC =
    (SELF_RESET_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int HOST_WAIT_W = 18;
  localparam int DEV_BUSY_W = 15;
  localparam logic [1:0] SCK_HALF = 2'h3;
  localparam logic [5:0] PIPE_PERIODS = 6'h02;
  localparam logic [5:0] GAP_PERIODS = 6'h04;
  // APB map of the host end
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [1:0] OP_WRITE_CTRL = 2'h1;
  localparam logic [1:0] OP_READ_CTRL = 2'h2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_WAIT_BIT = 2;
  localparam int STAT_STOP_BIT = 3;

  function automatic logic [7:0] hcb_status(input logic [3:0] res);
    return {4'h0, res};
  endfunction : hcb_status
endpackage : hcb_pkg
`default_nettype wire

/* pkg/hcb_if.sv */
// Serial link between the host end and the device end.
// Assumes the host drives sck free-running; bits go MSB first.
`default_nettype none
interface hcb_if;
  logic sck;
  logic sel;
  logic mosi;
  logic miso;
  modport dev (input sck, input sel, input mosi, output miso);
  modport host (output sck, output sel, output mosi, input miso);
endinterface : hcb_if
`default_nettype wire

/* rtl/hcb_dev.sv */
// Device end: control byte read and write commands over the serial link.
// Assumes sck runs freely from the host and rst is synchronous to sck.
`default_nettype none
module hcb_dev #(
  parameter int unsigned RESET_BUSY_CYC = hcb_pkg::DEV_RESET_CYC
) (
  // Link, clocked by its sck
  hcb_if.dev link,
  // Reset and enable
  input wire logic rst,
  input wire logic ce,
  // System area results and settings
  input wire logic [3:0] interrupt_source_select,
  input wire logic config_flag_check_error,
  input wire logic block_check_error,
  // RF side controls
  output logic [3:0] rf_irq_enable,
  output logic rf_comm_stop,
  output logic self_reset_busy
);
  import hcb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_RESP} hcb_dev_state_e;

  hcb_dev_state_e state_q;
  logic sel_m_q, sel_s_q, mosi_m_q, mosi_s_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] code_q;
  logic [15:0] out_q;
  logic miso_q;
  logic [7:0] ctrl_q;
  logic [DEV_BUSY_W-1:0] busy_cnt_q;
  logic [3:0] irq_en_q;
  logic stop_q;
  logic busy_q;
  logic [7:0] byte_in;
  logic code_done, wr_fire, respond, busy, self_reset_go;
  logic [15:0] resp;

  function automatic logic [7:0] hcb_readback(input logic [7:0] c,
                                              input logic cfg_err,
                                              input logic bcc_err);
    return {c[7:3], 1'b0, cfg_err, bcc_err};
  endfunction : hcb_readback

  // Two-flop synchronisers for the link pins
  always_ff @(posedge link.sck) begin
    if (rst) begin
      sel_m_q <= 1'b0;
      sel_s_q <= 1'b0;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
    end else if (ce) begin
      sel_m_q <= link.sel;
      sel_s_q <= sel_m_q;
      mosi_m_q <= link.mosi;
      mosi_s_q <= mosi_m_q;
    end
  end

  assign busy = busy_cnt_q != '0;
  assign byte_in = {sh_q[6:0], mosi_s_q};
  assign code_done = state_q == ST_CMD && sel_s_q && cnt_q == 4'h7;
  assign wr_fire = state_q == ST_CMD && sel_s_q && cnt_q == 4'hf
                   && code_q == CODE_WRITE_CTRL;
  // Self-reset starts once the frame carrying the answer has ended
  assign self_reset_go = ctrl_q[RESET_REQ_BIT] && !sel_s_q
                         && state_q == ST_IDLE;

  // Answer selection
  always_comb begin
    respond = 1'b0;
    resp = 16'h0000;
    if (code_done) begin
      if (busy) begin
        respond = 1'b1;
        resp = {hcb_status(RES_BUSY), 8'h00};
      end else if (byte_in == CODE_READ_CTRL) begin
        respond = 1'b1;
        resp = {hcb_status(RES_NORMAL),
                hcb_readback(ctrl_q, config_flag_check_error,
                             block_check_error)};
      end else if (byte_in != CODE_WRITE_CTRL) begin
        respond = 1'b1;
        resp = {hcb_status(RES_UNIMPL), 8'h00};
      end
    end else if (wr_fire) begin
      respond = 1'b1;
      resp = {hcb_status(RES_NORMAL), 8'h00};
    end
  end

  // Frame sequencer
  always_ff @(posedge link.sck) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      code_q <= 8'h00;
      out_q <= 16'h0000;
      miso_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          miso_q <= 1'b0;
          if (sel_s_q) begin
            state_q <= ST_CMD;
            sh_q <= {7'h00, mosi_s_q};
            cnt_q <= 4'h1;
          end
        end
        ST_CMD: begin
          if (!sel_s_q) begin
            state_q <= ST_IDLE;
          end else begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 4'h1;
            if (code_done) begin
              code_q <= byte_in;
            end
            if (respond) begin
              state_q <= ST_RESP;
              miso_q <= resp[15];
              out_q <= {resp[14:0], 1'b0};
            end
          end
        end
        ST_RESP: begin
          miso_q <= out_q[15];
          out_q <= {out_q[14:0], 1'b0};
          if (!sel_s_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Control byte
  always_ff @(posedge link.sck) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce) begin
      if (self_reset_go) begin
        ctrl_q <= CTRL_RESET;
      end else if (wr_fire) begin
        ctrl_q <= byte_in & ~CTRL_RSV_MASK;
      end
    end
  end

  // Self-reset busy period
  always_ff @(posedge link.sck) begin
    if (rst) begin
      busy_cnt_q <= '0;
    end else if (ce) begin
      if (self_reset_go) begin
        busy_cnt_q <= DEV_BUSY_W'(RESET_BUSY_CYC);
      end else if (busy) begin
        busy_cnt_q <= busy_cnt_q - DEV_BUSY_W'(1);
      end
    end
  end

  // RF side outputs
  always_ff @(posedge link.sck) begin
    if (rst) begin
      irq_en_q <= 4'h0;
      stop_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce) begin
      irq_en_q[3] <= interrupt_source_select[3]
                     & ~ctrl_q[MASK_RFWR_BIT];
      irq_en_q[2] <= interrupt_source_select[2]
                     & ~ctrl_q[MASK_RFRD_BIT];
      irq_en_q[1] <= interrupt_source_select[1]
                     & ~ctrl_q[MASK_RFTX_BIT];
      irq_en_q[0] <= interrupt_source_select[0]
                     & ~ctrl_q[MASK_FDET_BIT];
      stop_q <= ctrl_q[RF_STOP_BIT];
      busy_q <= busy;
    end
  end

  assign link.miso = miso_q;
  assign rf_irq_enable = irq_en_q;
  assign rf_comm_stop = stop_q;
  assign self_reset_busy = busy_q;
endmodule : hcb_dev
`default_nettype wire

/* verification/hcb_link_properties.sv */
// Checker on the serial link between host end and device end.
// Assumes sampling at sck rising, rst being the device reset.
`default_nettype none
module hcb_link_props (
  // Link domain
  input wire logic sck,
  input wire logic rst,
  // Link signals
  input wire logic sel,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sck);
  endclocking
  default disable iff (rst);
  // Command codes, MSB first
  sequence s_read_code;
    $rose(sel) && !mosi ##1 mosi ##1 mosi ##1 !mosi ##1 mosi ##1 !mosi [*3];
  endsequence
  sequence s_write_code;
    $rose(sel) && !mosi ##1 mosi [*4] ##1 !mosi [*3];
  endsequence
  // Status bytes
  sequence s_status_any;
    !miso [*5] ##1 miso ##1 1'b1 ##1 miso;
  endsequence
  sequence s_status_ok;
    !miso [*5] ##1 miso ##1 !miso ##1 miso;
  endsequence
  sequence s_status_busy;
    !miso [*5] ##1 miso [*3];
  endsequence
  // Read frames by the status they got
  sequence s_read_ok;
    s_read_code ##3 s_status_ok;
  endsequence
  sequence s_read_busy;
    s_read_code ##3 s_status_busy;
  endsequence
  a_read_status: assert property (s_read_code |-> ##3 s_status_any)
    else $error("read answer status malformed");
  a_read_length: assert property (s_read_ok |=> sel [*8] ##1 !sel)
    else $error("read frame not one data byte");
  a_read_rsv_zero: assert property (s_read_ok |-> ##6 !miso)
    else $error("reserved read bit not zero");
  a_busy_no_data: assert property (s_read_busy |=> !sel)
    else $error("data sent after busy status");
  a_write_status: assert property (s_write_code |-> ##11 s_status_any)
    else $error("write answer status malformed");
  a_write_length: assert property (s_write_code |-> ##18 sel ##1 !sel)
    else $error("write frame length wrong");
  a_write_rsv_zero: assert property (s_write_code |-> ##6 !mosi [*2])
    else $error("reserved write bits not zero");
  a_frame_gap: assert property ($fell(sel) |-> !sel [*4])
    else $error("frame gap too short");
endmodule : hcb_link_props
`default_nettype wire

/* verification/test_host_control_byte_commands.sv */
// Testbench joining host end and device end over the serial link.
// Assumes host makes sck from clk; device inputs change at sck fall.
`default_nettype none
module test_host_control_byte_commands;
  timeunit 1ns;
  timeprecision 1ns;
  import hcb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, dev_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, st, v, r;
  logic pready, pslverr, e;
  logic [3:0] irq_sel = 4'hf, rf_en;
  logic cfg_err = 1'b0, bcc_err = 1'b0, rf_stop, sr_busy;
  int num_errors = 0, compares = 0;
  hcb_if link ();
  always #10 clk = ~clk;
  hcb_host #(.RESET_WAIT_CYC(64)) hcb_host_inst (.clk(clk), .rst(rst),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  hcb_dev #(.RESET_BUSY_CYC(100)) hcb_dev_inst (.link(link), .rst(dev_rst),
    .ce(1'b1), .interrupt_source_select(irq_sel),
    .config_flag_check_error(cfg_err), .block_check_error(bcc_err),
    .rf_irq_enable(rf_en), .rf_comm_stop(rf_stop), .self_reset_busy(sr_busy));
  hcb_link_props hcb_link_props_inst (.sck(link.sck), .rst(dev_rst),
    .sel(link.sel), .mosi(link.mosi), .miso(link.miso));
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask : chk_byte
  task hang;
    chk_word(32'h0, 32'h1);
    summarize();
  endtask : hang
  // One APB transfer, entered just after a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Issue a command, wait for done, clear done
  task cmd(input logic [1:0] op, input logic [7:0] d, output logic [31:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 500);
    if (n >= 500) hang();
    apb(1'b1, ADDR_CMD, {22'h0, op, d}, r, e);
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, s, e);
      n++;
    end while (s[STAT_DONE_BIT] !== 1'b1 && n < 1000);
    if (n >= 1000) hang();
    apb(1'b1, ADDR_STAT, 32'h2, r, e);
  endtask : cmd
  task rd_ctrl;
    cmd(OP_READ_CTRL, 8'h00, st);
    apb(1'b0, ADDR_DATA, 32'h0, v, e);
  endtask : rd_ctrl
  task set_err(input logic c, input logic b);
    @(negedge link.sck);
    cfg_err <= c;
    bcc_err <= b;
    @(posedge clk);
  endtask : set_err
  task t_defaults;
    rd_ctrl();
    chk_byte(st[15:8], {4'h0, RES_NORMAL});
    chk_byte(v[7:0], CTRL_RESET);
    chk_byte({4'h0, rf_en}, 8'h0f);
    chk_byte({7'h0, rf_stop}, 8'h00);
  endtask : t_defaults
  task t_masks;
    for (int i = 4; i < 8; i++) begin
      cmd(OP_WRITE_CTRL, 8'h01 << i, st);
      chk_byte(st[15:8], {4'h0, RES_NORMAL});
      rd_ctrl();
      chk_byte(v[7:0], 8'h01 << i);
      chk_byte({4'h0, rf_en}, {4'h0, ~(4'h1 << (i - 4))});
    end
  endtask : t_masks
  task t_errbits;
    cmd(OP_WRITE_CTRL, 8'hfe, st);
    chk_byte({7'h0, st[STAT_STOP_BIT]}, 8'h01);
    apb(1'b0, ADDR_CMD, 32'h0, r, e);
    chk_word(r, {22'h0, OP_WRITE_CTRL, 8'hf8});
    for (int k = 0; k < 4; k++) begin
      set_err(k[1], k[0]);
      rd_ctrl();
      chk_byte(v[7:0], {5'h1f, 1'b0, k[1:0]});
    end
    chk_byte({7'h0, rf_stop}, 8'h01);
    chk_byte({4'h0, rf_en}, 8'h00);
    set_err(1'b0, 1'b0);
  endtask : t_errbits
  task t_release;
    int n;
    n = 0;
    cmd(OP_WRITE_CTRL, 8'h00, st);
    chk_byte(st[15:8], {4'h0, RES_NORMAL});
    apb(1'b0, ADDR_CMD, 32'h0, r, e);
    chk_word(r, {22'h0, OP_WRITE_CTRL, 8'h01});
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, r, e);
      n++;
    end while (r[STAT_WAIT_BIT] !== 1'b1 && r[STAT_BUSY_BIT] === 1'b1
               && n < 40);
    chk_byte({7'h0, r[STAT_WAIT_BIT]}, 8'h01);
    n = 0;
    while (sr_busy !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk_byte({7'h0, sr_busy}, 8'h01);
    rd_ctrl();
    chk_byte(st[15:8], {4'h0, RES_BUSY});
    n = 0;
    while (sr_busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) hang();
    rd_ctrl();
    chk_byte(st[15:8], {4'h0, RES_NORMAL});
    chk_byte(v[7:0], CTRL_RESET);
    chk_byte({3'h0, rf_stop, rf_en}, 8'h0f);
  endtask : t_release
  task t_unmapped;
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk_word({31'h0, e}, 32'h1);
    chk_word(r, 32'h0);
    apb(1'b1, ADDR_CMD, {22'h0, 2'h3, 8'h55}, r, e);
    apb(1'b0, ADDR_CMD, 32'h0, r, e);
    chk_word(r, {22'h0, OP_READ_CTRL, 8'h00});
  endtask : t_unmapped
  initial begin
    #1000000;
    hang();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge link.sck);
    dev_rst <= 1'b0;
    repeat (4) @(posedge link.sck);
    @(posedge clk);
    t_defaults();
    t_masks();
    t_errbits();
    t_release();
    t_unmapped();
    summarize();
  end
endmodule : test_host_control_byte_commands
`default_nettype wire
